// >>> hdl/ptm_pkg.sv
// package for the 8-bit period timer group: register map, field layout, reset values
// assumes one clock domain; register port addresses are word indices
package ptm_pkg;
  localparam int unsigned MAX_TIMERS = 5;
  localparam int unsigned ADDR_W = 5;
  // per-timer block of four register indices, three used: count, period, control
  localparam logic [4:0] OFS_COUNT = 5'h00;
  localparam logic [4:0] OFS_PERIOD = 5'h01;
  localparam logic [4:0] OFS_CONTROL = 5'h02;
  localparam logic [4:0] TIMER_STRIDE = 5'h04;
  localparam logic [4:0] ADDR_FLAG5 = 5'h14;
  localparam logic [4:0] ADDR_ENABLE5 = 5'h15;
  // control fields
  localparam int unsigned CTL_PRE_LSB = 0;
  localparam int unsigned CTL_RUN_BIT = 2;
  localparam int unsigned CTL_POST_LSB = 3;
  localparam logic [6:0] CTL_WRITE_MASK = 7'h7f;
  // reset values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [6:0] CONTROL_RESET = 7'h00;
  // prescale terminal counts (ratio minus one)
  localparam logic [3:0] PRE_TC_1 = 4'h0;
  localparam logic [3:0] PRE_TC_4 = 4'h3;
  localparam logic [3:0] PRE_TC_16 = 4'hf;
  // flag/enable bit positions per instance in the peripheral registers
  localparam logic [2:0] IRQ_BIT_POS [MAX_TIMERS] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6};

  typedef enum logic [1:0] {
    PTM_PRE_DIV1 = 2'b00,
    PTM_PRE_DIV4 = 2'b01,
    PTM_PRE_DIV16 = 2'b10
  } ptm_pre_type;

  // terminal prescale count for a select value
  function automatic logic [3:0] pre_tc(input logic [1:0] sel);
    if (sel == PTM_PRE_DIV1) begin
      return PRE_TC_1;
    end else if (sel == PTM_PRE_DIV4) begin
      return PRE_TC_4;
    end else begin
      return PRE_TC_16;
    end
  endfunction : pre_tc
endpackage : ptm_pkg

// >>> hdl/ptm_regs.sv
// control and period registers for one timer instance
// assumes write strobe and address decode come from the top
`timescale 1ns/1ps
module ptm_regs (
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset, active high
  input wire logic period_wr_i, // write period this cycle
  input wire logic ctl_wr_i, // write control this cycle
  input wire logic [7:0] wdata_i, // write data
  output logic [7:0] period_o, // period register
  output logic [6:0] ctl_o // control register, bit 7 reads zero
);
  logic [7:0] period_q, period_d;
  logic [6:0] ctl_q, ctl_d;

  always_comb begin
    period_d = period_wr_i ? wdata_i : period_q;
    ctl_d = ctl_wr_i ? (wdata_i[6:0] & ptm_pkg::CTL_WRITE_MASK) : ctl_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_q <= ptm_pkg::PERIOD_RESET;
      ctl_q <= ptm_pkg::CONTROL_RESET;
    end else begin
      period_q <= period_d;
      ctl_q <= ctl_d;
    end
  end

  assign period_o = period_q;
  assign ctl_o = ctl_q;
endmodule : ptm_regs

// >>> hdl/ptm_scaler.sv
// counting core for one timer instance: prescaler, count, period match, postscaler
// assumes clk_i is the instruction clock (oscillator divided by four)
`timescale 1ns/1ps
module ptm_scaler (
  input wire logic clk_i, // instruction clock
  input wire logic rst_i, // async reset, active high
  input wire logic [6:0] ctl_i, // control register value
  input wire logic [7:0] period_i, // period register value
  input wire logic count_wr_i, // software writes count this cycle
  input wire logic ctl_wr_i, // software writes control this cycle
  input wire logic [7:0] wdata_i, // write data
  output logic [7:0] count_o, // current count
  output logic match_o, // one-cycle wrap pulse, before postscaler
  output logic post_o // one-cycle postscaled event
);
  logic [3:0] pre_q, pre_d;
  logic [3:0] post_q, post_d;
  logic [7:0] cnt_q, cnt_d;
  logic match_q, match_d;
  logic post_ev_q, post_ev_d;
  logic tick;

  always_comb begin
    pre_d = pre_q;
    post_d = post_q;
    cnt_d = cnt_q;
    match_d = 1'b0;
    post_ev_d = 1'b0;
    tick = ctl_i[ptm_pkg::CTL_RUN_BIT] && (pre_q == ptm_pkg::pre_tc(ctl_i[ptm_pkg::CTL_PRE_LSB +: 2]));
    if (ctl_i[ptm_pkg::CTL_RUN_BIT]) begin
      pre_d = tick ? 4'h0 : pre_q + 4'h1;
    end
    if (tick) begin
      if (cnt_q == period_i) begin
        cnt_d = 8'h00;
        match_d = 1'b1;
        if (post_q == ctl_i[ptm_pkg::CTL_POST_LSB +: 4]) begin
          post_d = 4'h0;
          post_ev_d = 1'b1;
        end else begin
          post_d = post_q + 4'h1;
        end
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
    if (count_wr_i) begin
      cnt_d = wdata_i;
      pre_d = 4'h0;
      post_d = 4'h0;
    end
    if (ctl_wr_i) begin
      pre_d = 4'h0;
      post_d = 4'h0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q <= 4'h0;
      post_q <= 4'h0;
      cnt_q <= ptm_pkg::COUNT_RESET;
      match_q <= 1'b0;
      post_ev_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      post_q <= post_d;
      cnt_q <= cnt_d;
      match_q <= match_d;
      post_ev_q <= post_ev_d;
    end
  end

  assign count_o = cnt_q;
  assign match_o = match_q;
  assign post_o = post_ev_q;
endmodule : ptm_scaler

// >>> hdl/ptm_top.sv
// group of 8-bit period timers with prescaler, postscaler and shared flag/enable registers
// assumes a single-cycle register port; read data valid the cycle after the read strobe
`timescale 1ns/1ps
module ptm_top #(
  parameter int unsigned NUM_TIMERS = 5
) (
  input wire logic clk_i, // instruction clock, 25 MHz
  input wire logic rst_i, // async reset, active high
  input wire logic [4:0] addr_i, // register index
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  output logic [NUM_TIMERS-1:0] time_base_o, // per-timer match pulses to capture/PWM units
  output logic [NUM_TIMERS-1:0] irq_req_o // per-timer gated interrupt requests
);
  logic [7:0] period [NUM_TIMERS];
  logic [6:0] ctl [NUM_TIMERS];
  logic [7:0] count [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] match, post;
  logic [NUM_TIMERS-1:0] cnt_wr, per_wr, ctl_wr;
  logic [7:0] flag_q, flag_d, en_q, en_d, rdata_q, rdata_d;
  logic [NUM_TIMERS-1:0] tb_q, irq_q, irq_d;
  logic [7:0] impl_mask;

  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
    logic [4:0] base;
    assign base = 5'(g) * ptm_pkg::TIMER_STRIDE;
    assign cnt_wr[g] = wr_i && (addr_i == base + ptm_pkg::OFS_COUNT);
    assign per_wr[g] = wr_i && (addr_i == base + ptm_pkg::OFS_PERIOD);
    assign ctl_wr[g] = wr_i && (addr_i == base + ptm_pkg::OFS_CONTROL);
    ptm_regs u_regs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .period_wr_i(per_wr[g]),
      .ctl_wr_i(ctl_wr[g]),
      .wdata_i(wdata_i),
      .period_o(period[g]),
      .ctl_o(ctl[g])
    );
    ptm_scaler u_scaler (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ctl_i(ctl[g]),
      .period_i(period[g]),
      .count_wr_i(cnt_wr[g]),
      .ctl_wr_i(ctl_wr[g]),
      .wdata_i(wdata_i),
      .count_o(count[g]),
      .match_o(match[g]),
      .post_o(post[g])
    );
  end

  always_comb begin
    impl_mask = 8'h00;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      impl_mask[ptm_pkg::IRQ_BIT_POS[i]] = 1'b1;
    end
  end

  // flags: hardware set wins over a software write in the same cycle
  always_comb begin
    flag_d = flag_q;
    en_d = en_q;
    if (wr_i && addr_i == ptm_pkg::ADDR_FLAG5) begin
      flag_d = wdata_i & impl_mask;
    end
    if (wr_i && addr_i == ptm_pkg::ADDR_ENABLE5) begin
      en_d = wdata_i & impl_mask;
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (post[i]) begin
        flag_d[ptm_pkg::IRQ_BIT_POS[i]] = 1'b1;
      end
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      irq_d[i] = flag_d[ptm_pkg::IRQ_BIT_POS[i]] && en_d[ptm_pkg::IRQ_BIT_POS[i]];
    end
  end

  // read decode; unmapped indices read zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd_i) begin
      if (addr_i == ptm_pkg::ADDR_FLAG5) begin
        rdata_d = flag_q;
      end else if (addr_i == ptm_pkg::ADDR_ENABLE5) begin
        rdata_d = en_q;
      end else begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
          if (addr_i == 5'(i) * ptm_pkg::TIMER_STRIDE + ptm_pkg::OFS_COUNT) begin
            rdata_d = count[i];
          end else if (addr_i == 5'(i) * ptm_pkg::TIMER_STRIDE + ptm_pkg::OFS_PERIOD) begin
            rdata_d = period[i];
          end else if (addr_i == 5'(i) * ptm_pkg::TIMER_STRIDE + ptm_pkg::OFS_CONTROL) begin
            rdata_d = {1'b0, ctl[i]};
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_q <= 8'h00;
      en_q <= 8'h00;
      rdata_q <= 8'h00;
      tb_q <= '0;
      irq_q <= '0;
    end else begin
      flag_q <= flag_d;
      en_q <= en_d;
      rdata_q <= rdata_d;
      tb_q <= match;
      irq_q <= irq_d;
    end
  end

  assign rdata_o = rdata_q;
  assign time_base_o = tb_q;
  assign irq_req_o = irq_q;
endmodule : ptm_top

// >>> verification/ptm_monitor.sv
// port checker for ptm_top, timer 0 and the register port
// assumes timer 0 registers change only through port writes
`timescale 1ns/1ps
module ptm_monitor #(parameter int unsigned NUM_TIMERS = 5) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [4:0] addr_i, // index
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write
  input wire logic rd_i, // read
  input wire logic [7:0] rdata_o, // read data
  input wire logic [NUM_TIMERS-1:0] time_base_o, // time base
  input wire logic [NUM_TIMERS-1:0] irq_req_o // requests
);
  logic [7:0] per_q, per_d, ctl_q, ctl_d;
  logic [15:0] gap_q, gap_d, exp_gap;
  logic [1:0] ok_q, ok_d;
  logic en_q, en_d;
  always_comb begin
    per_d = (wr_i && addr_i == 5'h01) ? wdata_i : per_q;
    ctl_d = (wr_i && addr_i == 5'h02) ? wdata_i : ctl_q;
    en_d = (wr_i && addr_i == 5'h15) ? wdata_i[0] : en_q;
    gap_d = time_base_o[0] ? 16'h0001 : gap_q + 16'h0001;
    // two pulses after any write to a timer 0 register (index below 0x04) before the spacing is settled
    ok_d = (wr_i && addr_i < 5'h04) ? 2'h0 : ((time_base_o[0] && ok_q != 2'h3) ? ok_q + 2'h1 : ok_q);
    exp_gap = (16'(per_q) + 16'h1) << (ctl_q[1] ? 4 : (ctl_q[0] ? 2 : 0));
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      per_q <= 8'hff;
      ctl_q <= 8'h00;
      en_q <= 1'b0;
      gap_q <= 16'h0000;
      ok_q <= 2'h0;
    end else begin
      per_q <= per_d;
      ctl_q <= ctl_d;
      en_q <= en_d;
      gap_q <= gap_d;
      ok_q <= ok_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_halted;
    !ctl_q[2] [*4];
  endsequence
  rd_only_a: assert property (rdata_o != 8'h00 |-> $past(rd_i)) else $error("read data outside read slot");
  ctl_top_a: assert property (rd_i && addr_i == 5'h02 |=> !rdata_o[7]) else $error("control bit 7 set");
  flag_bits_a: assert property (rd_i && addr_i[4:1] == 4'ha |=> (rdata_o & (NUM_TIMERS == 3 ? 8'hea : 8'h8a)) == 8'h00)
    else $error("flag bit outside timer map");
  stop_a: assert property (s_halted |-> !time_base_o[0]) else $error("time base while stopped");
  gap_a: assert property (time_base_o[0] && ok_q >= 2'h2 |-> gap_q == exp_gap) else $error("period spacing");
  gate_a: assert property (irq_req_o[0] |-> en_q || $past(en_q)) else $error("request while disabled");
  sticky_a: assert property (irq_req_o[0] && !(wr_i && addr_i[4:1] == 4'ha) |=> irq_req_o[0]) else $error("flag lost");
  cause_a: assert property ($rose(irq_req_o[0]) && !$past(wr_i) && !$past(time_base_o[0]) |-> ##[0:2] time_base_o[0])
    else $error("request without match");
endmodule : ptm_monitor

// >>> verification/ptm_pwm_unit.sv
// capture/pwm unit model: counts time base beats of one timer
// assumes a one-cycle pulse per timer period
`timescale 1ns/1ps
module ptm_pwm_unit (
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset
  input wire logic time_base_i, // time base pulse
  output logic [15:0] beats_o // periods seen
);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      beats_o <= 16'h0000;
    end else if (time_base_i) begin
      beats_o <= beats_o + 16'h0001;
    end
  end
endmodule : ptm_pwm_unit

// >>> verification/testbench.sv
// testbench for ptm_top with three timers, lfsr stimulus from a fixed seed
// assumes ptm_monitor and ptm_pwm_unit are compiled first
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00, rdata_o, v, p;
  logic [2:0] time_base_o, irq_req_o;
  logic [15:0] beats, b0;
  logic [31:0] seed = 32'h8849;
  int err_total = 0, n_compared = 0, n, k;
  ptm_top #(.NUM_TIMERS(3)) u_ptm_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .time_base_o(time_base_o), .irq_req_o(irq_req_o));
  ptm_pwm_unit u_ptm_pwm_unit (.clk_i(clk_i), .rst_i(rst_i), .time_base_i(time_base_o[0]), .beats_o(beats));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string s, input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk("rdata", {8'h00, rdata_o}, {8'h00, e});
  endtask : rd
  task automatic wait_tb(output int c);
    c = 0;
    do begin
      @(negedge clk_i);
      c++;
    end while (time_base_o[0] !== 1'b1 && c < 9000);
    if (c >= 9000) begin
      err_total++;
      wrap_up();
    end
  endtask : wait_tb
  task automatic run0(input logic [7:0] per, input logic [7:0] ctl);
    wr(5'h02, 8'h00);
    wr(5'h00, 8'h00);
    wr(5'h14, 8'h00);
    wr(5'h01, per);
    wr(5'h02, ctl);
  endtask : run0
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(5'h00, 8'h00);
    rd(5'h09, 8'hff);
    rd(5'h1f, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      wr(5'h01, v);
      rd(5'h01, v);
      wr(5'h00, v);
      wr(5'h02, v & 8'hfb);
      rd(5'h00, v);
      rd(5'h02, v & 8'h7b);
    end
    for (int s = 0; s < 4; s++) begin
      p = (s == 0) ? 8'h00 : (rnd() & 8'h07);
      run0(p, 8'h04 | 8'(s));
      wait_tb(n);
      b0 = beats;
      wait_tb(n);
      wait_tb(n);
      chk("gap", 16'(n), (16'(p) + 16'h1) << (s == 0 ? 0 : (s == 1 ? 2 : 4)));
      chk("beats", beats, b0 + 16'h2);
    end
    // a count write mid-run restarts the prescaler phase, so the read lands in the middle of step one
    run0(8'hff, 8'h06);
    v = rnd();
    repeat (v[3:0]) @(posedge clk_i);
    wr(5'h00, 8'h00);
    repeat (21) @(posedge clk_i);
    rd(5'h00, 8'h01);
    wr(5'h02, 8'h00);
    wr(5'h00, 8'h5a);
    repeat (20) @(negedge clk_i);
    rd(5'h00, 8'h5a);
    wr(5'h15, 8'h01);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h00 : ((i == 1) ? 8'h0f : (rnd() & 8'h0f));
      run0(8'h03, {1'b0, v[3:0], 3'b100});
      k = 0;
      n = 0;
      while (irq_req_o[0] !== 1'b1 && n < 2000) begin
        @(negedge clk_i);
        n++;
        if (time_base_o[0] === 1'b1) k++;
      end
      if (n >= 2000) begin
        err_total++;
        wrap_up();
      end
      repeat (2) begin
        @(negedge clk_i);
        if (time_base_o[0] === 1'b1) k++;
      end
      chk("post", 16'(k), 16'(v) + 16'h1);
      wr(5'h15, 8'h00);
      repeat (2) @(negedge clk_i);
      chk("irq", {15'h0, irq_req_o[0]}, 16'h0);
      rd(5'h14, 8'h01);
      wr(5'h15, 8'h01);
      repeat (2) @(negedge clk_i);
      chk("irq", {15'h0, irq_req_o[0]}, 16'h1);
    end
    wr(5'h02, 8'h00);
    wr(5'h14, 8'h00);
    wr(5'h06, 8'h04);
    wr(5'h0a, 8'h04);
    repeat (600) @(negedge clk_i);
    rd(5'h14, 8'h14);
    wr(5'h14, 8'hff);
    rd(5'h14, 8'h15);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(5'h06, 8'h00);
    wrap_up();
  end
endmodule : testbench
bind ptm_top ptm_monitor #(.NUM_TIMERS(NUM_TIMERS)) u_ptm_monitor (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .time_base_o(time_base_o), .irq_req_o(irq_req_o));
